// file: hw/fis_pkg.sv
// Purpose: Shared constants and types for the function interrupt signaling block.
// Assumes: 32-bit AXI4-Lite register window with byte addresses below 0x40.
// Notes: Message kinds are the only enumeration that crosses module boundaries.
package fis_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PIN = 8'h04;
  localparam logic [7:0] ADDR_SRC_EN = 8'h08;
  localparam logic [7:0] ADDR_SRC_STAT = 8'h0c;
  localparam logic [7:0] ADDR_VEC_MASK = 8'h10;
  localparam logic [7:0] ADDR_MADDR_LO = 8'h14;
  localparam logic [7:0] ADDR_MADDR_HI = 8'h18;
  localparam logic [7:0] ADDR_MDATA = 8'h1c;
  localparam logic [7:0] ADDR_STATE = 8'h20;
  // Control register fields
  localparam int CTRL_DIS_BIT = 0;
  localparam int CTRL_MSI_BIT = 1;
  localparam int CTRL_MSIX_BIT = 2;
  localparam int CTRL_TC_LSB = 4;
  // Pin/line register fields
  localparam int PIN_LSB = 8;
  // State register fields
  localparam int ST_WIRE_BIT = 0;
  localparam int ST_MODE_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_PEND_LSB = 8;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [7:0] RST_LINE = 8'hff;
  // Link attribute, class and pin range values
  localparam logic [2:0] TC_ZERO = 3'h0;
  localparam logic [1:0] ATTR_ZERO = 2'h0;
  localparam logic [7:0] PIN_MIN = 8'h01;
  localparam logic [7:0] PIN_MAX = 8'h04;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {KIND_ASSERT, KIND_DEASSERT, KIND_MEMWR} fis_kind_e;
endpackage

// file: hw/fis_top.sv
// Purpose: Interrupt signaling for one link function, wire emulation and MSI/MSI-X.
// Assumes: Source events are one-cycle pulses from logic on clk_in.
// Notes: One message slot; the wire engine has priority over vectors.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// - Legacy interrupts go out as link messages; pin and line registers kept.
// - Four virtual wires A to D, each with assert and deassert messages.
// - Assert and deassert messages always go out as matched pairs.
// - The pin register reports 01 to 04, naming the wire used.
// - Wire mode and message mode are distinct, chosen by software settings.
// - An interrupting device implements MSI, MSI-X or both.
// - Each message-signaled interrupt is a memory write on the link.
// - Message-signaled interrupts are edge triggered only, never level.
// - Unmasking a vector with conditions still pending sends a new message.
// - Per-vector masking always for MSI-X, optional but advised for MSI.
// - A legacy endpoint with MSI supports the 32-bit or 64-bit address form.
// - A native endpoint with MSI supports the 64-bit address form.
// - No-snoop and relaxed-ordering attributes are zero on interrupt writes.
// - Wire messages use class TC0; interrupt writes may use any class.
// - Wire asserted only while disable bit is 0 and enabled condition pends.
// - One message each time unmasked, enabled, set goes false to true.
module fis_top
  import fis_pkg::*;
#(
  parameter int N_SRC = 8,               // Interrupt sources, one vector each
  parameter logic [7:0] PIN_VALUE = 8'h01, // Wire used: 1 A .. 4 D
  parameter bit MSI_PVM = 1'b1           // Per-vector masking also under MSI
) (
  input wire logic clk_in,                   // Core clock, 40 MHz
  input wire logic rst_n_in,                 // Async reset, active low
  input wire logic [7:0] s_axi_awaddr_in,    // Write address
  input wire logic s_axi_awvalid_in,         // Write address valid
  output logic s_axi_awready_out,            // Write address ready
  input wire logic [31:0] s_axi_wdata_in,    // Write data
  input wire logic [3:0] s_axi_wstrb_in,     // Write strobes
  input wire logic s_axi_wvalid_in,          // Write data valid
  output logic s_axi_wready_out,             // Write data ready
  output logic [1:0] s_axi_bresp_out,        // Write response
  output logic s_axi_bvalid_out,             // Write response valid
  input wire logic s_axi_bready_in,          // Write response ready
  input wire logic [7:0] s_axi_araddr_in,    // Read address
  input wire logic s_axi_arvalid_in,         // Read address valid
  output logic s_axi_arready_out,            // Read address ready
  output logic [31:0] s_axi_rdata_out,       // Read data
  output logic [1:0] s_axi_rresp_out,        // Read response
  output logic s_axi_rvalid_out,             // Read data valid
  input wire logic s_axi_rready_in,          // Read data ready
  input wire logic [N_SRC-1:0] src_event_in, // Interrupt condition pulses
  output logic msg_valid_out,                // Link message offered
  input wire logic msg_ready_in,             // Link takes message
  output logic [1:0] msg_kind_out,           // fis_kind_e code
  output logic [63:0] msg_addr_out,          // Write address, zero for wires
  output logic msg_addr64_out,               // 64-bit address form in use
  output logic [31:0] msg_data_out,          // Write data or wire index
  output logic [2:0] msg_tc_out,             // Traffic class
  output logic [1:0] msg_attr_out,           // No-snoop, relaxed ordering
  output logic wire_level_out                // Virtual wire level as sent
);
  localparam int VW = (N_SRC > 1) ? $clog2(N_SRC) : 1;

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic ctrl_dis;
    logic msi_en;
    logic msix_en;
    logic [2:0] msi_tc;
    logic [7:0] int_line;
    logic [N_SRC-1:0] src_en;
    logic [N_SRC-1:0] src_stat;
    logic [N_SRC-1:0] vec_mask;
    logic [31:0] maddr_lo;
    logic [31:0] maddr_hi;
    logic [31:0] mdata;
    logic [N_SRC-1:0] comb_prev;
    logic [N_SRC-1:0] vec_pend;
    logic m_valid;
    fis_kind_e m_kind;
    logic [63:0] m_addr;
    logic m_addr64;
    logic [31:0] m_data;
    logic [2:0] m_tc;
  } fis_state_s;

  fis_state_s q;
  fis_state_s d;
  fis_wire_if wire_if ();

  logic msi_mode;
  logic [N_SRC-1:0] cond;
  logic [N_SRC-1:0] mask_eff;
  logic [N_SRC-1:0] comb_now;
  logic slot_free;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Interrupt conditions and mode selection
  assign msi_mode = q.msi_en | q.msix_en;
  assign cond = q.src_stat & q.src_en;
  // MSI-X always masks; MSI masks only when the option is built in
  assign mask_eff = (q.msix_en || MSI_PVM) ? q.vec_mask : '0;
  assign comb_now = msi_mode ? (cond & ~mask_eff) : '0;
  assign wire_if.want = !q.ctrl_dis && !msi_mode && (|cond);
  assign slot_free = !q.m_valid || msg_ready_in;
  assign wire_if.grant = slot_free && wire_if.req;

  fis_vwire u_vwire (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wire_if(wire_if.engine)
  );

  // Bus handshakes
  assign s_axi_awready_out = !q.aw_got && !q.bvalid;
  assign s_axi_wready_out = !q.w_got && !q.bvalid;
  assign s_axi_arready_out = !q.rvalid;
  assign s_axi_bvalid_out = q.bvalid;
  assign s_axi_bresp_out = q.bresp;
  assign s_axi_rvalid_out = q.rvalid;
  assign s_axi_rdata_out = q.rdata;
  assign s_axi_rresp_out = q.rresp;

  // Link message port, data from the message registers, attributes tied to ATTR_ZERO
  assign msg_valid_out = q.m_valid;
  assign msg_kind_out = q.m_kind;
  assign msg_addr_out = q.m_addr;
  assign msg_addr64_out = q.m_addr64;
  assign msg_data_out = q.m_data;
  assign msg_tc_out = q.m_tc;
  assign msg_attr_out = ATTR_ZERO;
  assign wire_level_out = wire_if.asserted;

  // Next state: bus slave, registers, vector tracking, message slot
  always_comb begin
    logic [N_SRC-1:0] clr;
    logic [N_SRC-1:0] send;
    logic [VW-1:0] idx;
    logic [31:0] mw;
    d = q;
    clr = '0;
    send = '0;
    idx = '0;
    mw = '0;
    // Address and data may arrive in either order
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      d.aw_got = 1'b1;
      d.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      d.w_got = 1'b1;
      d.w_data = s_axi_wdata_in;
      d.w_strb = s_axi_wstrb_in;
    end
    if (q.bvalid && s_axi_bready_in) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      unique case (q.aw_addr)
        ADDR_CTRL: begin
          mw = merge({24'h0, 1'b0, q.msi_tc, 1'b0, q.msix_en, q.msi_en, q.ctrl_dis},
                     q.w_data, q.w_strb);
          d.ctrl_dis = mw[CTRL_DIS_BIT];
          d.msi_en = mw[CTRL_MSI_BIT];
          d.msix_en = mw[CTRL_MSIX_BIT];
          d.msi_tc = mw[CTRL_TC_LSB +: 3];
        end
        ADDR_PIN: d.int_line = 8'(merge({24'h0, q.int_line}, q.w_data, q.w_strb));
        ADDR_SRC_EN: d.src_en = N_SRC'(merge(32'(q.src_en), q.w_data, q.w_strb));
        ADDR_SRC_STAT: clr = N_SRC'(merge(32'h0, q.w_data, q.w_strb));
        ADDR_VEC_MASK: d.vec_mask = N_SRC'(merge(32'(q.vec_mask), q.w_data, q.w_strb));
        ADDR_MADDR_LO: d.maddr_lo = merge(q.maddr_lo, q.w_data, q.w_strb);
        ADDR_MADDR_HI: d.maddr_hi = merge(q.maddr_hi, q.w_data, q.w_strb);
        ADDR_MDATA: d.mdata = merge(q.mdata, q.w_data, q.w_strb);
        ADDR_STATE: d.bresp = RESP_OKAY;
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    // Reads answer one cycle after the address is taken
    if (q.rvalid && s_axi_rready_in) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = '0;
      unique case (s_axi_araddr_in)
        ADDR_CTRL: d.rdata = {24'h0, 1'b0, q.msi_tc, 1'b0, q.msix_en, q.msi_en, q.ctrl_dis};
        ADDR_PIN: d.rdata = {16'h0, PIN_VALUE, q.int_line};
        ADDR_SRC_EN: d.rdata = 32'(q.src_en);
        ADDR_SRC_STAT: d.rdata = 32'(q.src_stat);
        ADDR_VEC_MASK: d.rdata = 32'(q.vec_mask);
        ADDR_MADDR_LO: d.rdata = q.maddr_lo;
        ADDR_MADDR_HI: d.rdata = q.maddr_hi;
        ADDR_MDATA: d.rdata = q.mdata;
        ADDR_STATE: begin
          d.rdata[ST_WIRE_BIT] = wire_if.asserted;
          d.rdata[ST_MODE_BIT] = msi_mode;
          d.rdata[ST_BUSY_BIT] = q.m_valid;
          d.rdata[ST_PEND_LSB +: N_SRC] = q.vec_pend;
        end
        default: d.rresp = RESP_SLVERR;
      endcase
    end
    // Sticky status; a new event beats a clear in the same cycle
    d.src_stat = (q.src_stat & ~clr) | src_event_in;
    // Only false-to-true edges schedule a write, so no level form exists
    d.comb_prev = comb_now;
    d.vec_pend = (q.vec_pend | (comb_now & ~q.comb_prev)) & ~mask_eff;
    if (!msi_mode) begin
      d.vec_pend = '0;
    end
    send = d.vec_pend;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (send[i]) begin
        idx = VW'(i);
      end
    end
    // Message slot; the wire engine goes first
    if (q.m_valid && msg_ready_in) begin
      d.m_valid = 1'b0;
    end
    if (slot_free && wire_if.req) begin
      d.m_valid = 1'b1;
      d.m_kind = wire_if.req_assert ? KIND_ASSERT : KIND_DEASSERT;
      d.m_addr = '0;
      d.m_addr64 = 1'b0;
      d.m_data = 32'(2'(PIN_VALUE - PIN_MIN));
      d.m_tc = TC_ZERO;
    end else if (slot_free && (|send)) begin
      d.m_valid = 1'b1;
      d.m_kind = KIND_MEMWR;
      d.m_addr = {q.maddr_hi, q.maddr_lo[31:2], 2'b00};
      d.m_addr64 = |q.maddr_hi;
      d.m_data = q.mdata | 32'(idx);
      d.m_tc = q.msi_tc;
      d.vec_pend[idx] = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.int_line <= RST_LINE;
      q.m_kind <= KIND_ASSERT;
    end else begin
      q <= d;
    end
  end

  attr_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    msg_valid_out |-> (msg_attr_out == ATTR_ZERO))
    else $error("interrupt message with nonzero attributes");
  wire_class_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (msg_valid_out && (msg_kind_out != KIND_MEMWR)) |-> (msg_tc_out == TC_ZERO))
    else $error("wire message not on class zero");
  msi_no_assert_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (msi_mode && wire_if.req) |-> !wire_if.req_assert)
    else $error("wire assert requested in message mode");
  assert_cause_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wire_if.grant && wire_if.req_assert) |-> (!q.ctrl_dis && (|cond)))
    else $error("wire asserted without enabled pending condition");
  msi_edge_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ((|(comb_now & ~q.comb_prev)) && slot_free && !wire_if.req) |=>
      (msg_valid_out && (msg_kind_out == KIND_MEMWR)))
    else $error("condition edge did not launch a memory write");
  no_level_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ((comb_now & ~q.comb_prev) == '0) |=> ((q.vec_pend & ~$past(q.vec_pend)) == '0))
    else $error("vector scheduled without a condition edge");
  pin_range_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_axi_arvalid_in && s_axi_arready_out && (s_axi_araddr_in == ADDR_PIN)) |=>
      (s_axi_rdata_out[PIN_LSB +: 8] >= PIN_MIN && s_axi_rdata_out[PIN_LSB +: 8] <= PIN_MAX))
    else $error("pin register outside one to four");
  bresp_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_axi_bvalid_out && !s_axi_bready_in) |=> (s_axi_bvalid_out && $stable(s_axi_bresp_out)))
    else $error("write response dropped before taken");
  // Message port, mode separation and bus answer checks
  msg_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (msg_valid_out && !msg_ready_in) |=> (msg_valid_out && $stable(msg_kind_out)
      && $stable(msg_addr_out) && $stable(msg_data_out)))
    else $error("message changed before taken");
  memwr_form_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (msg_valid_out && (msg_kind_out == KIND_MEMWR)) |->
      ((msg_addr_out[1:0] == 2'b00) && (msg_addr64_out == (|msg_addr_out[63:32]))))
    else $error("memory write address form wrong");
  wire_index_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (msg_valid_out && (msg_kind_out != KIND_MEMWR)) |->
      (msg_data_out == 32'(PIN_VALUE - PIN_MIN)))
    else $error("wire message names the wrong wire");
  mode_apart_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    msi_mode |-> !wire_if.want)
    else $error("wire wanted in message mode");
  wire_stays_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (msi_mode && !wire_if.asserted) |=> !wire_if.asserted)
    else $error("wire asserted in message mode");
  dis_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (q.ctrl_dis && !wire_if.asserted) |=> !wire_if.asserted)
    else $error("wire asserted while disabled");
  msix_mask_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    q.msix_en |-> ((comb_now & q.vec_mask) == '0))
    else $error("masked vector live under MSI-X");
  pend_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !msi_mode |=> (q.vec_pend == '0))
    else $error("vector pending outside message mode");
  write_resp_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (q.aw_got && q.w_got) |=> s_axi_bvalid_out)
    else $error("write response missing");
  read_resp_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_axi_arvalid_in && s_axi_arready_out) |=> s_axi_rvalid_out)
    else $error("read response missing");
  rdata_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_axi_rvalid_out && !s_axi_rready_in) |=> (s_axi_rvalid_out && $stable(s_axi_rdata_out)))
    else $error("read data dropped before taken");
endmodule

// file: hw/fis_vwire.sv
// Purpose: Virtual interrupt wire engine that turns a level into message pairs.
// Assumes: Grant only arrives while req is high.
// Notes: Asserts and deasserts strictly alternate, starting from deasserted.
`timescale 1ns/1ps
module fis_vwire
  import fis_pkg::*;
(
  input wire logic clk_in,     // Core clock
  input wire logic rst_n_in,   // Async reset, active low
  fis_wire_if.engine wire_if   // Request port
);
  typedef enum logic {WIRE_LOW, WIRE_HIGH} fis_vw_e;
  typedef struct packed {
    fis_vw_e st;
  } fis_vw_s;
  fis_vw_s q;
  fis_vw_s d;

  // Message wanted whenever the sent level differs from the wanted one
  assign wire_if.req = (q.st == WIRE_LOW) ? wire_if.want : !wire_if.want;
  assign wire_if.req_assert = (q.st == WIRE_LOW);
  assign wire_if.asserted = (q.st == WIRE_HIGH);

  // Level only flips once the message is taken, keeping the pairs matched
  always_comb begin
    d = q;
    if (wire_if.grant && wire_if.req) begin
      unique case (q.st)
        WIRE_LOW: d.st = WIRE_HIGH;
        WIRE_HIGH: d.st = WIRE_LOW;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '{st: WIRE_LOW};
    end else begin
      q <= d;
    end
  end

  wire_pair_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wire_if.grant && wire_if.req && wire_if.req_assert) |=>
      (wire_if.asserted && !wire_if.req_assert))
    else $error("assert message not followed by asserted level");
  deassert_due_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wire_if.asserted && !wire_if.want) |-> (wire_if.req && !wire_if.req_assert))
    else $error("deassert not requested after condition cleared");
endmodule

// file: hw/fis_wire_if.sv
// Purpose: Carries one virtual wire request between controller and wire engine.
// Assumes: Both ends on the same clock.
// Notes: A request is taken in the cycle grant is high.
`timescale 1ns/1ps
interface fis_wire_if;
  logic want;       // Enabled condition pending, legacy mode
  logic grant;      // Output slot given to the wire engine
  logic req;        // Engine has a message to send
  logic req_assert; // 1 assert, 0 deassert
  logic asserted;   // Wire level as last sent
  modport engine (input want, input grant, output req, output req_assert, output asserted);
  modport ctrl (output want, output grant, input req, input req_assert, input asserted);
endinterface

// file: test/fis_link_model.sv
// Purpose: Link-side receiver for interrupt messages from the block.
// Assumes: Same clock as the block; ready may toggle to stall the sender.
// Notes: Keeps only the last taken message, a count and a pairing flag.
`timescale 1ns/1ps
module fis_link_model
  import fis_pkg::*;
(
  input wire logic clk_in,          // Core clock
  input wire logic rst_n_in,        // Async reset, active low
  input wire logic slow_in,         // Stall every other cycle
  input wire logic msg_valid_in,    // Message offered
  input wire logic [103:0] msg_in,  // Kind, address, form, data, class, attributes
  output logic msg_ready_out,       // Message taken at this edge
  output logic [103:0] last_out,    // Last taken message
  output logic [7:0] cnt_out,       // Messages taken so far
  output logic pair_err_out         // Same wire message twice in a row
);
  logic wire_up_q;
  // Take messages; slow mode toggles ready so held fields are exercised
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      msg_ready_out <= 1'b0;
      last_out <= '0;
      cnt_out <= 8'h00;
      pair_err_out <= 1'b0;
      wire_up_q <= 1'b0;
    end else begin
      msg_ready_out <= slow_in ? !msg_ready_out : 1'b1;
      if (msg_valid_in && msg_ready_out) begin
        last_out <= msg_in;
        cnt_out <= cnt_out + 8'h01;
        // One merged upstream level, mapped straight through
        if (msg_in[103:102] != 2'h2) begin
          wire_up_q <= !msg_in[102];
          if (wire_up_q == !msg_in[102]) pair_err_out <= 1'b1;
        end
      end
    end
  end
endmodule

// file: test/function_interrupt_signaling_test.sv
// Purpose: Self-checking bench for the interrupt signaling block.
// Assumes: Register bus driven as a single AXI4-Lite master, default parameters.
// Notes: Handshakes are sampled on the falling edge and acted on at the next rise.
`timescale 1ns/1ps
module function_interrupt_signaling_test
  import fis_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, src = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic slow = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  wire logic awready, wready, bvalid, arready, rvalid, mvalid, mready, a64, lvl, perr;
  wire logic [1:0] bresp, rresp, kind, attr;
  wire logic [31:0] rdata, mdata;
  wire logic [63:0] maddr;
  wire logic [2:0] tc;
  wire logic [103:0] last;
  wire logic [7:0] cnt;
  int bad_count = 0;
  int checks = 0;
  int seen = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  // Core clock, 25 ns period
  always #12.5 clk_in = !clk_in;
  fis_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .src_event_in(src),
    .msg_valid_out(mvalid), .msg_ready_in(mready), .msg_kind_out(kind),
    .msg_addr_out(maddr), .msg_addr64_out(a64), .msg_data_out(mdata), .msg_tc_out(tc),
    .msg_attr_out(attr), .wire_level_out(lvl));
  fis_link_model link (.clk_in(clk_in), .rst_n_in(rst_n_in), .slow_in(slow),
    .msg_valid_in(mvalid), .msg_in({kind, maddr, a64, mdata, tc, attr}),
    .msg_ready_out(mready), .last_out(last), .cnt_out(cnt), .pair_err_out(perr));
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [103:0] got, input logic [103:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang();
    $display("timeout waiting for the block");
    bad_count++;
    close_out();
  endtask
  // Write one word; address and data offered together, released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ah, wh, bh;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk_in);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      rs = bresp;
      @(posedge clk_in);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) break;
    end
    bready <= 1'b0;
    if (n == 50) hang();
  endtask
  // Read one word into rd and rs
  task automatic rd_reg(input logic [7:0] a);
    int n;
    logic ah, rh;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk_in);
      ah = arvalid & arready;
      rh = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clk_in);
      if (ah) arvalid <= 1'b0;
      if (rh) break;
    end
    rready <= 1'b0;
    if (n == 50) hang();
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge clk_in);
    src <= m;
    @(posedge clk_in);
    src <= 8'h00;
  endtask
  function automatic logic [103:0] mk(input logic [1:0] k, input logic [63:0] a,
                                      input logic f, input logic [31:0] d, input logic [2:0] t);
    return {k, a, f, d, t, ATTR_ZERO};
  endfunction
  // Next message taken by the link, compared whole
  task automatic get_msg(input logic [103:0] exp);
    int n;
    for (n = 0; n < 60; n++) begin
      @(negedge clk_in);
      if (cnt != seen[7:0]) break;
    end
    if (n == 60) hang();
    seen++;
    check("message", last, exp);
  endtask
  // Quiet window: no message may be taken
  task automatic no_msg();
    repeat (20) @(negedge clk_in);
    check("message count", {96'h0, cnt}, {96'h0, seen[7:0]});
  endtask
  task automatic t_regs();
    rd_reg(ADDR_PIN);
    check("pin reset", rd, {16'h0000, 8'h01, RST_LINE});
    wr(ADDR_PIN, 32'h0000_ff05);
    check("write response", rs, RESP_OKAY);
    wr(8'h3c, 32'h0000_0000);
    check("unmapped write", rs, RESP_SLVERR);
    rd_reg(ADDR_PIN);
    check("pin read only", rd, 32'h0000_0105);
    rd_reg(8'h3c);
    check("unmapped", rs, RESP_SLVERR);
  endtask
  task automatic t_wire();
    wr(ADDR_SRC_EN, 32'h0000_00ff);
    pulse(8'h01);
    get_msg(mk(KIND_ASSERT, 64'h0, 1'b0, 32'h0, TC_ZERO));
    check("level up", lvl, 1'b1);
    rd_reg(ADDR_STATE);
    check("state", rd, 32'h1 << ST_WIRE_BIT);
    wr(ADDR_SRC_STAT, 32'h0000_0001);
    get_msg(mk(KIND_DEASSERT, 64'h0, 1'b0, 32'h0, TC_ZERO));
    check("level down", lvl, 1'b0);
  endtask
  task automatic t_disable();
    wr(ADDR_CTRL, 32'h0000_0001);
    pulse(8'h01);
    no_msg();
    wr(ADDR_SRC_STAT, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0000);
    no_msg();
  endtask
  task automatic t_mode();
    pulse(8'h01);
    get_msg(mk(KIND_ASSERT, 64'h0, 1'b0, 32'h0, TC_ZERO));
    wr(ADDR_CTRL, 32'h0000_0002);
    get_msg(mk(KIND_DEASSERT, 64'h0, 1'b0, 32'h0, TC_ZERO));
    get_msg(mk(KIND_MEMWR, 64'h0, 1'b0, 32'h0, TC_ZERO));
  endtask
  task automatic t_msi();
    wr(ADDR_SRC_STAT, 32'h0000_00ff);
    wr(ADDR_MADDR_LO, 32'h1000_0040);
    wr(ADDR_MADDR_HI, 32'h0000_0001);
    wr(ADDR_MDATA, 32'h0000_0050);
    wr(ADDR_CTRL, 32'h0000_0032);
    @(posedge clk_in);
    slow <= 1'b1;
    pulse(8'h04);
    get_msg(mk(KIND_MEMWR, 64'h1_1000_0040, 1'b1, 32'h52, 3'h3));
    pulse(8'h04);
    no_msg();
    wr(ADDR_SRC_STAT, 32'h0000_0004);
    pulse(8'h04);
    get_msg(mk(KIND_MEMWR, 64'h1_1000_0040, 1'b1, 32'h52, 3'h3));
  endtask
  task automatic t_mask();
    wr(ADDR_VEC_MASK, 32'h0000_0008);
    pulse(8'h08);
    no_msg();
    wr(ADDR_VEC_MASK, 32'h0000_0000);
    get_msg(mk(KIND_MEMWR, 64'h1_1000_0040, 1'b1, 32'h53, 3'h3));
  endtask
  task automatic t_msix();
    wr(ADDR_SRC_STAT, 32'h0000_00ff);
    wr(ADDR_MADDR_HI, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0004);
    pulse(8'h02);
    get_msg(mk(KIND_MEMWR, 64'h1000_0040, 1'b0, 32'h51, TC_ZERO));
    check("pairing", perr, 1'b0);
  endtask
  // Reset for four cycles, then each scenario in turn
  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_wire();
    t_disable();
    t_mode();
    t_msi();
    t_mask();
    t_msix();
    close_out();
  end
endmodule
